// ---- scsr_pkg.sv ----
// Package: map, field layout, reset values and carriers of the system config and status bank
package scsr_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_PIN_LEVELS = 12'h0dc;
    localparam logic [ADDR_W-1:0] OFF_STRAP = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_RTC_PRESENT = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_SAMPLE_EDGE = 12'h10c;
    localparam logic [ADDR_W-1:0] OFF_BONDING = 12'h110;
    localparam logic [ADDR_W-1:0] OFF_PIN_SHARING = 12'h200;

    // ****************************************
    // Reset values and writable masks
    // ****************************************
    localparam logic [DATA_W-1:0] SAMPLE_EDGE_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SAMPLE_EDGE_WMASK = 32'h0000_0003;
    localparam logic [DATA_W-1:0] PIN_SHARING_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PIN_SHARING_WMASK = 32'hc080_001e;

    // ****************************************
    // Field positions: dedicated pin input levels
    // ****************************************
    localparam int LVL_SUSPEND_POS = 21;
    localparam int LVL_WAKE_LSB = 16;
    localparam int LVL_GPIO_LSB = 0;

    // ****************************************
    // Field positions: strap status
    // ****************************************
    localparam int STRAP_POWER_BUTTON_POS = 31;
    localparam int STRAP_OSC_BYPASS_POS = 30;
    localparam int STRAP_REDUCED_MII_POS = 29;
    localparam int STRAP_MII_ACTIVE_POS = 28;
    localparam int STRAP_SIX_UART_POS = 24;
    localparam int STRAP_OUT_CLOCK_SEL_LSB = 21;
    localparam int STRAP_CLOCK_25M_SRC_POS = 20;
    localparam int STRAP_CLOCK_24M_SRC_POS = 19;
    localparam int STRAP_USB_SW_POS = 18;
    localparam int STRAP_PLL_REF_POS = 17;
    localparam int STRAP_FLASH_EDGE_POS = 14;
    localparam int STRAP_PLL_MODE_LSB = 10;
    localparam int STRAP_KEYPAD_POS = 7;
    localparam int STRAP_ADDR_CYC_LSB = 5;
    localparam int STRAP_PAGE_POS = 4;
    localparam int STRAP_FLASH_ADDR_POS = 3;
    localparam int STRAP_BOOT_SRC_LSB = 1;

    // ****************************************
    // Field positions: control registers
    // ****************************************
    localparam int RTC_PRESENT_POS = 0;
    localparam int SAMPLE_OVERRIDE_POS = 1;
    localparam int SAMPLE_NEGEDGE_POS = 0;
    localparam int BOND_LSB = 0;
    localparam int PS_VIDEO_OUT_EN_POS = 31;
    localparam int PS_VGA_EN_POS = 30;
    localparam int PS_VIDEO_CLK_INV_POS = 23;
    localparam int PS_NOR_SEL_POS = 4;
    localparam int PS_CLOCK_PIN_24M_POS = 3;
    localparam int PS_MCLK_EN_POS = 2;
    localparam int PS_AC97_SEL_POS = 1;

    // ****************************************
    // Timing: synchroniser settle before strap capture
    // ****************************************
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic power_button_required;
        logic ring_oscillator_bypass;
        logic reduced_variant_mii;
        logic mii_mode_active;
        logic six_uart_mode;
        logic [2:0] clock_output_select;
        logic clock_25m_from_crystal;
        logic clock_24m_from_crystal;
        logic usb_detect_by_sw;
        logic pll_ref_crystal_27m;
        logic serial_flash_posedge;
        logic [1:0] pll_clock_mode;
        logic keypad_unit_enable;
        logic [1:0] boot_addr_cycles;
        logic boot_page_mode;
        logic serial_flash_addr_size;
        logic [1:0] boot_source;
    } scsr_strap_t;

    typedef struct packed {
        logic [7:0] gpio;
        logic [3:0] wake_inputs;
        logic suspend_domain_pin;
        logic [2:0] bonding_config;
        logic rtc_clock_present;
    } scsr_live_t;

    typedef struct packed {
        logic digital_video_out_en;
        logic analog_display_en;
        logic video_clock_invert;
        logic nor_select;
        logic clock_output_24m_en;
        logic audio_master_clock_en;
        logic ac97_select;
        logic serial_flash_posedge;
    } scsr_ctrl_t;

endpackage

// ---- scsr_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module scsr_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    // ****************************************
    // One pair of flops per bit
    // ****************************************
    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    stage1[b] <= 1'b0;
                    stage2[b] <= 1'b0;
                end else if (ce_i) begin
                    stage1[b] <= async_i[b];
                    stage2[b] <= stage1[b];
                end
            end
        end
    endgenerate

    assign sync_o = stage2;

endmodule

// ---- scsr_regs.sv ----
// System configuration and status register bank behind an APB slave port
//
// Overview of operation
// - Bit 21 of pin-level register reads the suspend-domain pin live.
// - Bits 19:16 of pin-level register read the four wake inputs live.
// - Bits 7:0 of pin-level register read the eight dedicated pins live.
// - Strap bit 31: zero auto power-on, one needs power button.
// - Strap bit 30: zero ring oscillator used, one oscillator bypassed.
// - Strap bit 29 picks MII or reduced MII; bit 28 flags mode active.
// - Strap bits 20, 19: 25/24 MHz clock from PLL or 24 MHz crystal.
// - Strap bit 18: zero USB attach detect by hardware, one by software.
// - Strap bit 17: PLL reference from oscillator or 27 MHz crystal.
// - Strap bit 14: strapped serial flash edge, one means positive.
// - Strap bits 11:10 expose the PLL and divisor mode, read-only.
// - Strap bits 6:1 expose boot source, address size, page, cycles.
// - RTC-present register bit 0 shows clock presence, resets zero.
// - Sample-edge bit 1 clear follows strap, set follows bit 0.
// - Under override, sample-edge bit 0 zero means positive edge.
// - Bonding register returns three config inputs in bits 2:0.
// - Pin-sharing bits 31, 30 enable digital video and analog display.
// - Pin-sharing bit 23 inverts the video clock for internal use.
// - Pin-sharing bit 4 routes flash pins to NAND (0) or NOR (1).
// - Pin-sharing bit 3 puts a 24 MHz clock on the output pin.
// - Pin-sharing bit 2 gates the audio master clock output.
// - Pin-sharing bit 1 routes audio pins to I2S (0) or AC97 (1).
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module scsr_regs
    import scsr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire scsr_live_t live_pins_i,
    input wire scsr_strap_t strap_pins_i,
    input wire logic video_clock_i,
    input wire logic clock_24m_i,
    input wire logic clock_output_other_i,
    input wire logic audio_master_clock_i,
    output scsr_ctrl_t ctrl_o,
    output logic video_clock_internal_o,
    output logic clock_output_pin_o,
    output logic audio_master_clock_o,
    output logic audio_master_clock_oe_o
);

    localparam int LIVE_W = $bits(scsr_live_t);
    localparam int STRAP_W = $bits(scsr_strap_t);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [LIVE_W+STRAP_W-1:0] pins_async;
    logic [LIVE_W+STRAP_W-1:0] pins_sync;
    scsr_live_t live;
    scsr_strap_t strap_sync;

    assign pins_async = {live_pins_i, strap_pins_i};

    scsr_sync #(
        .W(LIVE_W + STRAP_W)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i(pins_async),
        .sync_o(pins_sync)
    );

    assign live = scsr_live_t'(pins_sync[LIVE_W+STRAP_W-1:STRAP_W]);
    assign strap_sync = scsr_strap_t'(pins_sync[STRAP_W-1:0]);

    // ****************************************
    // Strap capture
    // ****************************************
    // Straps are caught once after reset, when the synchroniser holds
    // real pin levels; later pin activity must not disturb them.
    logic [1:0] settle_cnt;
    logic strap_done;
    scsr_strap_t strap;
    wire capture_now = ce_i && !strap_done && (settle_cnt == STRAP_SETTLE_CYCLES);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            settle_cnt <= 2'h0;
            strap_done <= 1'b0;
        end else if (ce_i && !strap_done) begin
            settle_cnt <= settle_cnt + 2'h1;
            strap_done <= capture_now;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            strap <= '0;
        end else if (capture_now) begin
            strap <= strap_sync;
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    wire access_done = psel_i && penable_i && pready_o;
    wire hit_levels = (paddr_i == OFF_PIN_LEVELS);
    wire hit_strap = (paddr_i == OFF_STRAP);
    wire hit_rtc = (paddr_i == OFF_RTC_PRESENT);
    wire hit_sample = (paddr_i == OFF_SAMPLE_EDGE);
    wire hit_bond = (paddr_i == OFF_BONDING);
    wire hit_share = (paddr_i == OFF_PIN_SHARING);
    wire hit_any = hit_levels || hit_strap || hit_rtc || hit_sample || hit_bond || hit_share;
    wire wr_sample = access_done && pwrite_i && hit_sample;
    wire wr_share = access_done && pwrite_i && hit_share;

    // ****************************************
    // Writable registers
    // ****************************************
    logic [DATA_W-1:0] sample_edge_ctl;
    logic [DATA_W-1:0] pin_sharing;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sample_edge_ctl <= SAMPLE_EDGE_RST;
            pin_sharing <= PIN_SHARING_RST;
        end else if (ce_i) begin
            if (wr_sample) begin
                sample_edge_ctl <= pwdata_i & SAMPLE_EDGE_WMASK;
            end
            if (wr_share) begin
                pin_sharing <= pwdata_i & PIN_SHARING_WMASK;
            end
        end
    end

    // ****************************************
    // Read words
    // ****************************************
    logic [DATA_W-1:0] levels_word;
    logic [DATA_W-1:0] strap_word;
    logic [DATA_W-1:0] rtc_word;
    logic [DATA_W-1:0] bond_word;

    always_comb begin
        levels_word = '0;
        levels_word[LVL_SUSPEND_POS] = live.suspend_domain_pin;
        levels_word[LVL_WAKE_LSB +: 4] = live.wake_inputs;
        levels_word[LVL_GPIO_LSB +: 8] = live.gpio;
    end

    always_comb begin
        strap_word = '0;
        strap_word[STRAP_POWER_BUTTON_POS] = strap.power_button_required;
        strap_word[STRAP_OSC_BYPASS_POS] = strap.ring_oscillator_bypass;
        strap_word[STRAP_REDUCED_MII_POS] = strap.reduced_variant_mii;
        strap_word[STRAP_MII_ACTIVE_POS] = strap.mii_mode_active;
        strap_word[STRAP_SIX_UART_POS] = strap.six_uart_mode;
        strap_word[STRAP_OUT_CLOCK_SEL_LSB +: 3] = strap.clock_output_select;
        strap_word[STRAP_CLOCK_25M_SRC_POS] = strap.clock_25m_from_crystal;
        strap_word[STRAP_CLOCK_24M_SRC_POS] = strap.clock_24m_from_crystal;
        strap_word[STRAP_USB_SW_POS] = strap.usb_detect_by_sw;
        strap_word[STRAP_PLL_REF_POS] = strap.pll_ref_crystal_27m;
        strap_word[STRAP_FLASH_EDGE_POS] = strap.serial_flash_posedge;
        strap_word[STRAP_PLL_MODE_LSB +: 2] = strap.pll_clock_mode;
        strap_word[STRAP_KEYPAD_POS] = strap.keypad_unit_enable;
        strap_word[STRAP_ADDR_CYC_LSB +: 2] = strap.boot_addr_cycles;
        strap_word[STRAP_PAGE_POS] = strap.boot_page_mode;
        strap_word[STRAP_FLASH_ADDR_POS] = strap.serial_flash_addr_size;
        strap_word[STRAP_BOOT_SRC_LSB +: 2] = strap.boot_source;
    end

    always_comb begin
        rtc_word = '0;
        rtc_word[RTC_PRESENT_POS] = live.rtc_clock_present;
        bond_word = '0;
        bond_word[BOND_LSB +: 3] = live.bonding_config;
    end

    wire [DATA_W-1:0] read_mux =
        ({DATA_W{hit_levels}} & levels_word) |
        ({DATA_W{hit_strap}} & strap_word) |
        ({DATA_W{hit_rtc}} & rtc_word) |
        ({DATA_W{hit_sample}} & sample_edge_ctl) |
        ({DATA_W{hit_bond}} & bond_word) |
        ({DATA_W{hit_share}} & pin_sharing);

    // ****************************************
    // APB answer
    // ****************************************
    // Read data is sampled in the setup cycle so it leaves a flop; the
    // cost is that live levels are one cycle old at the access edge.
    // A setup cycle missed while frozen is taken in the access phase,
    // so a request never hangs.
    logic data_ok;
    wire take_req = psel_i && !data_ok;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prdata_o <= '0;
            pslverr_o <= 1'b0;
            data_ok <= 1'b0;
        end else if (ce_i) begin
            if (take_req) begin
                prdata_o <= pwrite_i ? '0 : read_mux;
                pslverr_o <= !hit_any;
                data_ok <= 1'b1;
            end else if (access_done) begin
                data_ok <= 1'b0;
            end
        end
    end

    assign pready_o = psel_i && penable_i && data_ok && ce_i;

    // ****************************************
    // Control outputs and pin routing
    // ****************************************
    wire sample_override = sample_edge_ctl[SAMPLE_OVERRIDE_POS];
    wire sample_neg_sel = sample_edge_ctl[SAMPLE_NEGEDGE_POS];

    assign ctrl_o.serial_flash_posedge = sample_override ? !sample_neg_sel
                                                         : strap.serial_flash_posedge;
    assign ctrl_o.digital_video_out_en = pin_sharing[PS_VIDEO_OUT_EN_POS];
    assign ctrl_o.analog_display_en = pin_sharing[PS_VGA_EN_POS];
    assign ctrl_o.video_clock_invert = pin_sharing[PS_VIDEO_CLK_INV_POS];
    assign ctrl_o.nor_select = pin_sharing[PS_NOR_SEL_POS];
    assign ctrl_o.clock_output_24m_en = pin_sharing[PS_CLOCK_PIN_24M_POS];
    assign ctrl_o.audio_master_clock_en = pin_sharing[PS_MCLK_EN_POS];
    assign ctrl_o.ac97_select = pin_sharing[PS_AC97_SEL_POS];

    // Clock paths are plain gates; no flop may sit on them
    assign video_clock_internal_o = video_clock_i ^ pin_sharing[PS_VIDEO_CLK_INV_POS];
    assign clock_output_pin_o = pin_sharing[PS_CLOCK_PIN_24M_POS] ? clock_24m_i
                                                                  : clock_output_other_i;
    assign audio_master_clock_o = audio_master_clock_i & pin_sharing[PS_MCLK_EN_POS];
    assign audio_master_clock_oe_o = pin_sharing[PS_MCLK_EN_POS];

endmodule

// ---- scsr_regs_checker.sv ----
// Checker: bus answers, write effects and pin routing of the config bank
`timescale 1ns/1ps
module scsr_regs_checker
    import scsr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [DATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic video_clock_i,
    input wire logic clock_24m_i,
    input wire logic clock_output_other_i,
    input wire logic audio_master_clock_i,
    input wire scsr_ctrl_t ctrl_o,
    input wire logic video_clock_internal_o,
    input wire logic clock_output_pin_o,
    input wire logic audio_master_clock_o,
    input wire logic audio_master_clock_oe_o
);
    // ****************************************
    // Helpers
    // ****************************************
    wire setup = psel_i && !penable_i && ce_i;
    wire wr_done = psel_i && penable_i && pready_o && pwrite_i;
    wire mapped = paddr_i == OFF_PIN_LEVELS || paddr_i == OFF_STRAP || paddr_i == OFF_RTC_PRESENT
        || paddr_i == OFF_SAMPLE_EDGE || paddr_i == OFF_BONDING || paddr_i == OFF_PIN_SHARING;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ****************************************
    // Assertions
    // ****************************************
    a_unmapped_err: assert property (setup |=> pslverr_o == !$past(mapped))
        else $error("slave error flag disagrees with address map");
    a_rtc_reserved: assert property (setup && paddr_i == OFF_RTC_PRESENT |=> prdata_o[31:1] == 31'h0)
        else $error("clock presence upper bits not zero");
    a_bond_upper: assert property (setup && paddr_i == OFF_BONDING |=> prdata_o[31:3] == 29'h0)
        else $error("bonding upper bits not zero");
    a_level_gaps: assert property (setup && paddr_i == OFF_PIN_LEVELS
        |=> {prdata_o[31:22], prdata_o[20], prdata_o[15:8]} == 19'h0)
        else $error("pin level reserved bits not zero");
    a_share_write: assert property (wr_done && paddr_i == OFF_PIN_SHARING
        |=> ctrl_o[7:1] == {$past(pwdata_i[31:30]), $past(pwdata_i[23]), $past(pwdata_i[4:1])})
        else $error("pin sharing controls do not follow write");
    a_edge_override: assert property (wr_done && paddr_i == OFF_SAMPLE_EDGE && pwdata_i[1]
        |=> ctrl_o.serial_flash_posedge == !$past(pwdata_i[0]))
        else $error("overridden flash edge wrong");
    a_clock_output_pin_mux: assert property (clock_output_pin_o
        == (ctrl_o.clock_output_24m_en ? clock_24m_i : clock_output_other_i))
        else $error("clock output pin source wrong");
    a_vid_invert: assert property (video_clock_internal_o == (video_clock_i ^ ctrl_o.video_clock_invert))
        else $error("internal video clock polarity wrong");
    a_mclk_gate: assert property (audio_master_clock_oe_o == ctrl_o.audio_master_clock_en
        && audio_master_clock_o == (audio_master_clock_i && ctrl_o.audio_master_clock_en))
        else $error("audio master clock gating wrong");
    a_reset_clear: assert property (disable iff (1'b0) rst_i |=> ctrl_o[7:1] == 7'h0 && !pslverr_o)
        else $error("controls not cleared by reset");
endmodule

bind scsr_regs scsr_regs_checker u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .video_clock_i(video_clock_i), .clock_24m_i(clock_24m_i),
    .clock_output_other_i(clock_output_other_i), .audio_master_clock_i(audio_master_clock_i), .ctrl_o(ctrl_o),
    .video_clock_internal_o(video_clock_internal_o), .clock_output_pin_o(clock_output_pin_o),
    .audio_master_clock_o(audio_master_clock_o), .audio_master_clock_oe_o(audio_master_clock_oe_o));

// ---- scsr_regs_tb.sv ----
// Testbench: APB access, live pins, straps and pin routing of the config bank
`timescale 1ns/1ps
module scsr_regs_tb
    import scsr_pkg::*;
();
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o, err;
    logic [ADDR_W-1:0] paddr_i = 12'h000;
    logic [DATA_W-1:0] pwdata_i = 32'h0, prdata_o, rd;
    logic vid_clk_int, clk_pin, mclk, mclk_oe;
    logic [3:0] ck = 4'h0;
    scsr_live_t live = 17'h00000;
    scsr_strap_t strap = 22'h35a96d;
    scsr_ctrl_t ctrl;
    int num_errors = 0, compares = 0;
    logic [16:0] pats [4] = '{17'h1ffff, 17'h00000, 17'h0b4a5, 17'h14b5a};
    logic [31:0] wpats [5] = '{32'hffffffff, 32'h00000000, 32'haaaaaaaa, 32'h55555555, 32'h00800008};
    logic [31:0] epats [6] = '{32'h3, 32'h2, 32'h1, 32'hfffffffc, 32'hffffffff, 32'h0};
    logic [11:0] ro [4] = '{OFF_PIN_LEVELS, OFF_STRAP, OFF_RTC_PRESENT, OFF_BONDING};
    logic [11:0] bad [3] = '{12'h108, 12'h102, 12'hffc};

    initial forever #50 sys_clk_i = ~sys_clk_i;
    // Free-running pin clocks, so every routing path sees both levels
    always @(posedge sys_clk_i) ck <= ck + 4'h1;

    scsr_regs u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .live_pins_i(live), .strap_pins_i(strap), .video_clock_i(ck[0]),
        .clock_24m_i(ck[1]), .clock_output_other_i(ck[2]), .audio_master_clock_i(ck[3]), .ctrl_o(ctrl),
        .video_clock_internal_o(vid_clk_int), .clock_output_pin_o(clk_pin), .audio_master_clock_o(mclk),
        .audio_master_clock_oe_o(mclk_oe));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Values read out are taken at the edge where pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        @(posedge sys_clk_i);
        // Only the watchdog ends a wait that never sees pready
        while (pready_o !== 1'b1) begin
            @(posedge sys_clk_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    function automatic logic [31:0] sw(input logic [21:0] s);
        return {s[21:18], 3'h0, s[17:10], 2'h0, s[9], 2'h0, s[8:7], 2'h0, s[6:0], 1'h0};
    endfunction

    function automatic logic [31:0] lvl(input logic [16:0] l);
        return {10'h0, l[4], 1'h0, l[8:5], 8'h0, l[16:9]};
    endfunction

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        rd_chk("share_rst", OFF_PIN_SHARING, 32'h0);
        rd_chk("edge_rst", OFF_SAMPLE_EDGE, 32'h0);
        rd_chk("rtc_rst", OFF_RTC_PRESENT, 32'h0);
        rd_chk("strap", OFF_STRAP, sw(strap));
        chk("err_ok", {31'h0, err}, 32'h0);
        chk("ctrl_rst", {24'h0, ctrl}, {31'h0, strap.serial_flash_posedge});
        foreach (pats[i]) begin
            live <= pats[i];
            repeat (3) @(posedge sys_clk_i);
            rd_chk("levels", OFF_PIN_LEVELS, lvl(pats[i]));
            rd_chk("bond", OFF_BONDING, {29'h0, pats[i][3:1]});
            rd_chk("rtc", OFF_RTC_PRESENT, {31'h0, pats[i][0]});
        end
        foreach (wpats[i]) begin
            xfer(1'b1, OFF_PIN_SHARING, wpats[i]);
            rd_chk("share", OFF_PIN_SHARING, wpats[i] & 32'hc080001e);
            chk("ctrl", {25'h0, ctrl[7:1]}, {25'h0, wpats[i][31:30], wpats[i][23], wpats[i][4:1]});
        end
        foreach (epats[i]) begin
            xfer(1'b1, OFF_SAMPLE_EDGE, epats[i]);
            rd_chk("edge", OFF_SAMPLE_EDGE, epats[i] & 32'h3);
            chk("flash_edge", {31'h0, ctrl.serial_flash_posedge},
                {31'h0, epats[i][1] ? !epats[i][0] : strap.serial_flash_posedge});
        end
        foreach (ro[i]) begin
            xfer(1'b1, ro[i], 32'hffffffff);
        end
        rd_chk("strap_ro", OFF_STRAP, sw(strap));
        rd_chk("bond_ro", OFF_BONDING, {29'h0, pats[3][3:1]});
        rd_chk("lvl_ro", OFF_PIN_LEVELS, lvl(pats[3]));
        foreach (bad[i]) begin
            xfer(1'b0, bad[i], 32'h0);
            chk("err", {31'h0, err}, 32'h1);
            chk("err_data", rd, 32'h0);
        end
        // Second reset in mid-run must clear controls and take fresh straps
        xfer(1'b1, OFF_PIN_SHARING, 32'hffffffff);
        strap <= 22'h0a5692;
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        rd_chk("share_rst2", OFF_PIN_SHARING, 32'h0);
        rd_chk("strap2", OFF_STRAP, sw(strap));
        chk("edge_rst2", {31'h0, ctrl.serial_flash_posedge}, 32'h1);
        // Frozen enable: the request must wait, then complete
        ce_i <= 1'b0;
        fork
            begin
                repeat (5) @(posedge sys_clk_i);
                ce_i <= 1'b1;
            end
        join_none
        rd_chk("ce_hold", OFF_BONDING, {29'h0, pats[3][3:1]});
        finish_test();
    end
endmodule
